// file: hdl/pin_mux_pkg.sv
// constants shared by the port pin function select block
// Summary of operation
// - Pin n of the lower port half is steered by bits 2n+1:2n of the low select register.
// - Field code 00 picks the default general-purpose function, 01, 10 and 11 the first, second and third alternates.
// - Only the selected function drives or sees a pin; all other candidates are cut off from it.
// - A converter input stays wired to its pin whatever function the pin carries.
// - The analog path is enabled, and the digital pad disabled, only while the analog code is selected.
// - The direction register steers a pin only under general-purpose I/O; otherwise the function sets direction.
// - Two read/write select registers sit at 0xE002C000 and 0xE002C004, both resetting to zero.
// - The zero reset value covers the implemented bits; every bit of both registers here is implemented.
// - Pins 0 to 3 map codes 01/10 to UART0 transmit/receive, I2C0 lines and timer3/timer0 lines; 11 is reserved.
// - Pins 4 to 7 map codes 01/10 to the SPI0 lines and timer0/timer2 lines; 11 is reserved.
// - Pins 8 to 11 map to UART1 transmit, receive, RTS, CTS, timer2/timer1 lines and converter channels 3 and 4.
// - Pins 12 to 15 map to UART1 modem lines, timer1 lines, channel 5, external interrupts 1/2 and SSP1 clock.
package pin_mux_pkg;

    // register map, byte addresses
    localparam logic [31:0] ADDR_SEL_LOW   = 32'hE002C000;
    localparam logic [31:0] ADDR_SEL_HIGH  = 32'hE002C004;
    localparam logic [31:0] SEL_LOW_RESET  = 32'h00000000;
    localparam logic [31:0] SEL_HIGH_RESET = 32'h00000000;

    // pin and field layout
    localparam int          NUM_PINS  = 16;
    localparam int          FIELD_W   = 2;
    localparam int          NUM_CODES = 4;

    // function codes of one field
    localparam logic [1:0]  FUNC_GPIO = 2'h0;
    localparam logic [1:0]  FUNC_ALT1 = 2'h1;
    localparam logic [1:0]  FUNC_ALT2 = 2'h2;
    localparam logic [1:0]  FUNC_ALT3 = 2'h3;

    // pins that host converter channels 3, 4 and 5
    localparam int          ADC_PIN_CH3 = 10;
    localparam int          ADC_PIN_CH4 = 11;
    localparam int          ADC_PIN_CH5 = 12;
    localparam int          NUM_ADC     = 3;

    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic        HRESP_OKAY    = 1'h0;

    // levels seen by a peripheral input whose pin is elsewhere
    localparam logic        IDLE_HIGH = 1'h1;
    localparam logic        IDLE_LOW  = 1'h0;

    // pad outputs out of reset: released, low
    localparam logic        PAD_OEN_RESET = 1'h1;
    localparam logic        PAD_OUT_RESET = 1'h0;

endpackage

// file: hdl/pin_input_sync.sv
// two-flop synchroniser for the pad inputs
`timescale 1ns/1ps

module pin_input_sync
    import pin_mux_pkg::*;
(
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // pad side and clock side
    input  wire logic [NUM_PINS-1:0] async_in,
    output logic      [NUM_PINS-1:0] sync_out
);

    logic [NUM_PINS-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: hdl/port_pin_function_select.sv
// pin function multiplexer for port pins 0 to 15 with its AHB-Lite select registers
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module port_pin_function_select
    import pin_mux_pkg::*;
(
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,

    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,

    // package pads, oen low while driving
    input  wire logic [NUM_PINS-1:0] pad_in,
    output logic      [NUM_PINS-1:0] pad_out,
    output logic      [NUM_PINS-1:0] pad_oen,
    output logic      [NUM_PINS-1:0] pad_digital_en,
    output logic      [NUM_ADC-1:0]  adc_path_en,

    // general-purpose I/O path
    input  wire logic [NUM_PINS-1:0] gpio_out,
    input  wire logic [NUM_PINS-1:0] port_direction_reg,
    output logic      [NUM_PINS-1:0] gpio_in,

    // UART0
    input  wire logic                uart0_transmit,
    output logic                     uart0_receive,

    // I2C0, open drain
    input  wire logic                i2c0_clock_line_drive_low,
    input  wire logic                i2c0_data_line_drive_low,
    output logic                     i2c0_clock_line_in,
    output logic                     i2c0_data_line_in,

    // SPI0, direction set by the peripheral
    input  wire logic                spi0_clock_out,
    input  wire logic                spi0_clock_drive,
    output logic                     spi0_clock_in,
    input  wire logic                spi0_follower_out_out,
    input  wire logic                spi0_follower_out_drive,
    output logic                     spi0_follower_out_in,
    input  wire logic                spi0_leader_out_out,
    input  wire logic                spi0_leader_out_drive,
    output logic                     spi0_leader_out_in,
    output logic                     spi0_select,

    // SSP1 clock
    input  wire logic                ssp1_clock_out,
    input  wire logic                ssp1_clock_drive,
    output logic                     ssp1_clock_in,

    // UART1 and modem lines
    input  wire logic                uart1_transmit,
    output logic                     uart1_receive,
    input  wire logic                uart1_request_to_send,
    output logic                     uart1_clear_to_send,
    output logic                     uart1_set_ready,
    input  wire logic                uart1_terminal_ready,
    output logic                     uart1_carrier_detect,
    output logic                     uart1_ring_indicator,

    // timer match outputs
    input  wire logic                timer0_match0,
    input  wire logic                timer0_match1,
    input  wire logic                timer1_match0,
    input  wire logic                timer1_match1,
    input  wire logic                timer2_match0,
    input  wire logic                timer2_match1,
    input  wire logic                timer2_match2,
    input  wire logic                timer3_match1,
    input  wire logic                timer3_match2,

    // timer capture inputs
    output logic                     timer0_capture0,
    output logic                     timer0_capture1,
    output logic                     timer0_capture2,
    output logic                     timer1_capture0,
    output logic                     timer1_capture1,

    // external interrupts
    output logic                     external_interrupt_1,
    output logic                     external_interrupt_2
);

    // ************************************************************
    // register bus
    // ************************************************************

    logic [31:0]         pin_select_low_half_q;
    logic [31:0]         pin_select_high_half_q;
    logic                wr_low_q;
    logic                wr_high_q;
    logic [31:0]         rdata_q;
    logic                take;
    logic                hit_low;
    logic                hit_high;
    logic [31:0]         low_now;
    logic [31:0]         high_now;

    // zero wait states, never an error
    assign hreadyout = 1'h1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_q;

    assign take     = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign hit_low  = (haddr == ADDR_SEL_LOW);
    assign hit_high = (haddr == ADDR_SEL_HIGH);

    // a write finishing this edge is forwarded to a read taken at the same edge
    assign low_now  = wr_low_q ? hwdata : pin_select_low_half_q;
    assign high_now = wr_high_q ? hwdata : pin_select_high_half_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_low_q  <= 1'h0;
            wr_high_q <= 1'h0;
        end else begin
            wr_low_q  <= take && hwrite && hit_low;
            wr_high_q <= take && hwrite && hit_high;
        end
    end

    // whole 32-bit registers, every bit kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_select_low_half_q  <= SEL_LOW_RESET;
            pin_select_high_half_q <= SEL_HIGH_RESET;
        end else begin
            if (wr_low_q) begin
                pin_select_low_half_q <= hwdata;
            end
            if (wr_high_q) begin
                pin_select_high_half_q <= hwdata;
            end
        end
    end

    // unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else if (take && !hwrite) begin
            if (hit_low) begin
                rdata_q <= low_now;
            end else if (hit_high) begin
                rdata_q <= high_now;
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // pad inputs
    // ************************************************************

    logic [NUM_PINS-1:0] pin_sync;

    pin_input_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // ************************************************************
    // per-pin function table
    // ************************************************************

    logic [1:0]          code [NUM_PINS];
    logic                fn_drv [NUM_PINS][NUM_CODES];
    logic                fn_val [NUM_PINS][NUM_CODES];

    // reserved and input-only entries keep drv low, so the pad floats
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            for (int c = 0; c < NUM_CODES; c++) begin
                fn_drv[p][c] = 1'h0;
                fn_val[p][c] = 1'h0;
            end
        end
        // pins 0 to 3
        fn_drv[0][FUNC_ALT1]  = 1'h1;
        fn_val[0][FUNC_ALT1]  = uart0_transmit;
        fn_drv[0][FUNC_ALT2]  = 1'h1;
        fn_val[0][FUNC_ALT2]  = timer3_match1;
        fn_drv[1][FUNC_ALT2]  = 1'h1;
        fn_val[1][FUNC_ALT2]  = timer3_match2;
        fn_drv[2][FUNC_ALT1]  = i2c0_clock_line_drive_low;
        fn_drv[3][FUNC_ALT1]  = i2c0_data_line_drive_low;
        fn_drv[3][FUNC_ALT2]  = 1'h1;
        fn_val[3][FUNC_ALT2]  = timer0_match0;
        // pins 4 to 7
        fn_drv[4][FUNC_ALT1]  = spi0_clock_drive;
        fn_val[4][FUNC_ALT1]  = spi0_clock_out;
        fn_drv[5][FUNC_ALT1]  = spi0_follower_out_drive;
        fn_val[5][FUNC_ALT1]  = spi0_follower_out_out;
        fn_drv[5][FUNC_ALT2]  = 1'h1;
        fn_val[5][FUNC_ALT2]  = timer0_match1;
        fn_drv[6][FUNC_ALT1]  = spi0_leader_out_drive;
        fn_val[6][FUNC_ALT1]  = spi0_leader_out_out;
        fn_drv[7][FUNC_ALT2]  = 1'h1;
        fn_val[7][FUNC_ALT2]  = timer2_match0;
        // pins 8 to 11
        fn_drv[8][FUNC_ALT1]  = 1'h1;
        fn_val[8][FUNC_ALT1]  = uart1_transmit;
        fn_drv[8][FUNC_ALT2]  = 1'h1;
        fn_val[8][FUNC_ALT2]  = timer2_match1;
        fn_drv[9][FUNC_ALT2]  = 1'h1;
        fn_val[9][FUNC_ALT2]  = timer2_match2;
        fn_drv[10][FUNC_ALT1] = 1'h1;
        fn_val[10][FUNC_ALT1] = uart1_request_to_send;
        // pins 12 to 15
        fn_drv[12][FUNC_ALT2] = 1'h1;
        fn_val[12][FUNC_ALT2] = timer1_match0;
        fn_drv[13][FUNC_ALT2] = 1'h1;
        fn_val[13][FUNC_ALT2] = timer1_match1;
        fn_drv[13][FUNC_ALT3] = 1'h1;
        fn_val[13][FUNC_ALT3] = uart1_terminal_ready;
        fn_drv[14][FUNC_ALT2] = ssp1_clock_drive;
        fn_val[14][FUNC_ALT2] = ssp1_clock_out;
    end

    // ************************************************************
    // pad drive
    // ************************************************************

    logic [NUM_PINS-1:0] adc_sel;

    assign adc_sel = '0 | ({{(NUM_PINS-1){1'h0}}, 1'h1} << ADC_PIN_CH3)
                        | ({{(NUM_PINS-1){1'h0}}, 1'h1} << ADC_PIN_CH4)
                        | ({{(NUM_PINS-1){1'h0}}, 1'h1} << ADC_PIN_CH5);

    for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
        logic gpio_mode;
        logic drive;
        logic value;
        logic analog_mode;

        assign code[n]     = pin_select_low_half_q[FIELD_W*n +: FIELD_W];
        assign gpio_mode   = (code[n] == FUNC_GPIO);
        assign analog_mode = adc_sel[n] && (code[n] == FUNC_ALT3);
        // direction from the port register only under general-purpose I/O
        assign drive = gpio_mode ? port_direction_reg[n] : fn_drv[n][code[n]];
        assign value = gpio_mode ? gpio_out[n] : fn_val[n][code[n]];
        // gpio sees nothing while another function owns the pin
        assign gpio_in[n] = gpio_mode ? pin_sync[n] : 1'h0;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pad_out[n]        <= PAD_OUT_RESET;
                pad_oen[n]        <= PAD_OEN_RESET;
                pad_digital_en[n] <= 1'h1;
            end else begin
                pad_out[n]        <= value;
                pad_oen[n]        <= !drive;
                pad_digital_en[n] <= !analog_mode;
            end
        end
    end

    // analog path only on the analog code; the converter wire itself is never cut
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_path_en <= '0;
        end else begin
            adc_path_en[0] <= (code[ADC_PIN_CH3] == FUNC_ALT3);
            adc_path_en[1] <= (code[ADC_PIN_CH4] == FUNC_ALT3);
            adc_path_en[2] <= (code[ADC_PIN_CH5] == FUNC_ALT3);
        end
    end

    // ************************************************************
    // peripheral inputs, idle level unless routed
    // ************************************************************

    // an unrouted peripheral never sees pad activity
    assign uart0_receive        = (code[1] == FUNC_ALT1) ? pin_sync[1] : IDLE_HIGH;
    assign i2c0_clock_line_in   = (code[2] == FUNC_ALT1) ? pin_sync[2] : IDLE_HIGH;
    assign timer0_capture0      = (code[2] == FUNC_ALT2) ? pin_sync[2] : IDLE_LOW;
    assign i2c0_data_line_in    = (code[3] == FUNC_ALT1) ? pin_sync[3] : IDLE_HIGH;
    assign spi0_clock_in        = (code[4] == FUNC_ALT1) ? pin_sync[4] : IDLE_LOW;
    assign timer0_capture1      = (code[4] == FUNC_ALT2) ? pin_sync[4] : IDLE_LOW;
    assign spi0_follower_out_in = (code[5] == FUNC_ALT1) ? pin_sync[5] : IDLE_LOW;
    assign spi0_leader_out_in   = (code[6] == FUNC_ALT1) ? pin_sync[6] : IDLE_LOW;
    assign timer0_capture2      = (code[6] == FUNC_ALT2) ? pin_sync[6] : IDLE_LOW;
    assign spi0_select          = (code[7] == FUNC_ALT1) ? pin_sync[7] : IDLE_HIGH;
    assign uart1_receive        = (code[9] == FUNC_ALT1) ? pin_sync[9] : IDLE_HIGH;
    assign timer1_capture0      = (code[10] == FUNC_ALT2) ? pin_sync[10] : IDLE_LOW;
    assign uart1_clear_to_send  = (code[11] == FUNC_ALT1) ? pin_sync[11] : IDLE_HIGH;
    assign timer1_capture1      = (code[11] == FUNC_ALT2) ? pin_sync[11] : IDLE_LOW;
    assign uart1_set_ready      = (code[12] == FUNC_ALT1) ? pin_sync[12] : IDLE_HIGH;
    assign external_interrupt_1 = (code[14] == FUNC_ALT1) ? pin_sync[14] : IDLE_LOW;
    assign ssp1_clock_in        = (code[14] == FUNC_ALT2) ? pin_sync[14] : IDLE_LOW;
    assign uart1_carrier_detect = (code[14] == FUNC_ALT3) ? pin_sync[14] : IDLE_HIGH;
    assign external_interrupt_2 = (code[15] == FUNC_ALT1) ? pin_sync[15] : IDLE_LOW;
    assign uart1_ring_indicator = (code[15] == FUNC_ALT3) ? pin_sync[15] : IDLE_HIGH;

endmodule

// file: verification/port_pin_function_select_asserts.sv
// concurrent checks on the ports of the pin function select block
`timescale 1ns/1ps

module port_pin_function_select_chk
    import pin_mux_pkg::*;
(
    // bus
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    // pads and pin 0 sources
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oen,
    input wire logic [NUM_PINS-1:0] pad_digital_en,
    input wire logic [NUM_ADC-1:0]  adc_path_en,
    input wire logic [NUM_PINS-1:0] gpio_out,
    input wire logic [NUM_PINS-1:0] port_direction_reg,
    input wire logic                uart0_transmit
);
    // ********************************
    // low select register mirror
    // ********************************
    logic        tk;
    logic        up_q;
    logic        wr_q;
    logic [31:0] lo_q;

    assign tk = hsel && hready && htrans[1];

    // pad flops lag the register by one edge, so up_q skips the first edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 1'h0;
            wr_q <= 1'h0;
            lo_q <= SEL_LOW_RESET;
        end else begin
            up_q <= 1'h1;
            wr_q <= tk && hwrite && haddr == ADDR_SEL_LOW;
            if (wr_q) begin
                lo_q <= hwdata;
            end
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_lo; tk && !hwrite && haddr == ADDR_SEL_LOW; endsequence
    sequence s_rd_off; tk && !hwrite && haddr != ADDR_SEL_LOW && haddr != ADDR_SEL_HIGH; endsequence
    sequence s_sel0(logic [1:0] c); up_q && $past(lo_q[1:0]) == c; endsequence

    property p_rd_lo; s_rd_lo |=> hrdata == lo_q; endproperty
    a_rd_lo: assert property (p_rd_lo) else $error("low select read-back wrong");
    property p_rd_off; s_rd_off |=> hrdata == 32'h00000000; endproperty
    a_rd_off: assert property (p_rd_off) else $error("unmapped read not zero");
    property p_hold; !(tk && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_gpio_dir; s_sel0(FUNC_GPIO) |-> pad_oen[0] == !$past(port_direction_reg[0]); endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("pin 0 direction wrong");
    property p_gpio_out;
        s_sel0(FUNC_GPIO) ##0 $past(port_direction_reg[0]) |-> pad_out[0] == $past(gpio_out[0]);
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("pin 0 gpio value wrong");
    property p_uart0; s_sel0(FUNC_ALT1) |-> !pad_oen[0] && pad_out[0] == $past(uart0_transmit); endproperty
    a_uart0: assert property (p_uart0) else $error("pin 0 uart drive wrong");
    property p_resv; s_sel0(FUNC_ALT3) |-> pad_oen[0]; endproperty
    a_resv: assert property (p_resv) else $error("reserved pin 0 driven");
    property p_adc;
        up_q |-> adc_path_en[0] == ($past(lo_q[21:20]) == FUNC_ALT3) && pad_digital_en[10] == !adc_path_en[0];
    endproperty
    a_adc: assert property (p_adc) else $error("pin 10 analog gate wrong");
endmodule

bind port_pin_function_select port_pin_function_select_chk u_port_pin_function_select_chk (.*);

// file: verification/periph_pad_model.sv
// on-chip peripherals and board pins around the pin multiplexer
`timescale 1ns/1ps

module periph_pad_model
    import pin_mux_pkg::*;
(
    // controls
    input  wire logic                hclk,
    input  wire logic                run,
    input  wire logic [22:0]         pat,
    input  wire logic [NUM_PINS-1:0] ext_lvl,
    // block side
    input  wire logic [NUM_PINS-1:0] pad_out,
    input  wire logic [NUM_PINS-1:0] pad_oen,
    output logic      [NUM_PINS-1:0] pad_in,
    output logic      [22:0]         periph_o
);
    // peripherals sit idle until run is raised, whatever the routing
    always_ff @(posedge hclk) begin
        periph_o <= run ? pat : 23'h000000;
    end

    // pin level: the block wins where it drives, the board elsewhere
    assign pad_in = (pad_oen & ext_lvl) | (~pad_oen & pad_out);
endmodule

// file: verification/port_pin_function_select_tb.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ps

module port_pin_function_select_tb
    import pin_mux_pkg::*;
;
    logic        hclk = 1'h0, hresetn, hsel, hwrite, hready, hreadyout, hresp, run;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [22:0] pat, periph_o;
    logic [19:0] in_v;
    logic [15:0] pad_in, pad_out, pad_oen, pad_digital_en, gpio_out, port_direction_reg, gpio_in, ext_lvl;
    logic [2:0]  hsize, adc_path_en;
    logic [1:0]  htrans;
    logic        uart0_transmit, timer3_match1, timer3_match2, i2c0_clock_line_drive_low, i2c0_data_line_drive_low,
                 timer0_match0, spi0_clock_out, spi0_clock_drive, spi0_follower_out_out, spi0_follower_out_drive,
                 timer0_match1, spi0_leader_out_out, spi0_leader_out_drive, timer2_match0, uart1_transmit,
                 timer2_match1, timer2_match2, uart1_request_to_send, timer1_match0, timer1_match1,
                 uart1_terminal_ready, ssp1_clock_out, ssp1_clock_drive;
    logic        uart0_receive, i2c0_clock_line_in, timer0_capture0, i2c0_data_line_in, spi0_clock_in,
                 timer0_capture1, spi0_follower_out_in, spi0_leader_out_in, timer0_capture2, spi0_select,
                 uart1_receive, timer1_capture0, uart1_clear_to_send, timer1_capture1, uart1_set_ready,
                 external_interrupt_1, ssp1_clock_in, uart1_carrier_detect, external_interrupt_2,
                 uart1_ring_indicator;
    int          n_fail = 0, cmp_count = 0;

    // entries {pin, code, released, level}, checked with pattern 23'h555555
    localparam logic [7:0] OUT_TAB [25] = '{8'h05, 8'h08, 8'h0E, 8'h19, 8'h1E, 8'h26, 8'h34, 8'h38, 8'h46,
        8'h59, 8'h64, 8'h78, 8'h85, 8'h88, 8'h99, 8'hA4, 8'hAE, 8'hBE, 8'hCE, 8'hC9, 8'hD6, 8'hD8, 8'hDD,
        8'hE8, 8'hFA};
    // entry k {pin, code} feeds bit k of in_v
    localparam logic [5:0] IN_TAB [20] = '{6'h05, 6'h09, 6'h0A, 6'h0D, 6'h11, 6'h12, 6'h15, 6'h19, 6'h1A,
        6'h1D, 6'h25, 6'h2A, 6'h2D, 6'h2E, 6'h31, 6'h39, 6'h3A, 6'h3B, 6'h3D, 6'h3F};
    localparam logic [19:0] IN_IDLE = 20'hA560B;

    port_pin_function_select u_port_pin_function_select (.*);
    periph_pad_model         u_periph_pad_model (.*);

    assign hready = hreadyout;
    assign {ssp1_clock_drive, ssp1_clock_out, uart1_terminal_ready, timer1_match1, timer1_match0,
            uart1_request_to_send, timer2_match2, timer2_match1, uart1_transmit, timer2_match0,
            spi0_leader_out_drive, spi0_leader_out_out, timer0_match1, spi0_follower_out_drive,
            spi0_follower_out_out, spi0_clock_drive, spi0_clock_out, timer0_match0, i2c0_data_line_drive_low,
            i2c0_clock_line_drive_low, timer3_match2, timer3_match1, uart0_transmit} = periph_o;
    assign in_v = {uart1_ring_indicator, external_interrupt_2, uart1_carrier_detect, ssp1_clock_in,
                   external_interrupt_1, uart1_set_ready, timer1_capture1, uart1_clear_to_send, timer1_capture0,
                   uart1_receive, spi0_select, timer0_capture2, spi0_leader_out_in, spi0_follower_out_in,
                   timer0_capture1, spi0_clock_in, i2c0_data_line_in, timer0_capture0, i2c0_clock_line_in,
                   uart0_receive};

    always #20 hclk = ~hclk;

    // ********************************
    // helpers
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // single word transfer; each phase held until hready is seen high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge hclk);
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hready !== 1'h1 && n < 50);
            if (n >= 50) begin
                n_fail++;
                summarize();
            end
            htrans <= 2'h0;
            hwdata <= d;
        end
        r = hrdata;
        chk(hresp, HRESP_OKAY);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_regs();
        bus(1'h0, ADDR_SEL_LOW, 32'h0, r);
        chk(r, SEL_LOW_RESET);
        bus(1'h0, ADDR_SEL_HIGH, 32'h0, r);
        chk(r, SEL_HIGH_RESET);
        bus(1'h1, ADDR_SEL_LOW, 32'hC3A55A3C, r);
        bus(1'h1, ADDR_SEL_HIGH, 32'h87654321, r);
        bus(1'h1, ADDR_SEL_HIGH + 32'h8, 32'hFFFFFFFF, r);
        bus(1'h0, ADDR_SEL_LOW, 32'h0, r);
        chk(r, 32'hC3A55A3C);
        bus(1'h0, ADDR_SEL_HIGH, 32'h0, r);
        chk(r, 32'h87654321);
        bus(1'h0, ADDR_SEL_HIGH + 32'h8, 32'h0, r);
        chk(r, 32'h00000000);
        hsel <= 1'h0;
        bus(1'h1, ADDR_SEL_LOW, 32'hFFFFFFFF, r);
        hsel <= 1'h1;
        bus(1'h0, ADDR_SEL_LOW, 32'h0, r);
        chk(r, 32'hC3A55A3C);
        bus(1'h1, ADDR_SEL_LOW, 32'h0, r);
        $display("test regs done");
    endtask

    task automatic t_gpio();
        port_direction_reg <= 16'hA5C3;
        gpio_out           <= 16'h3C96;
        ext_lvl            <= 16'h5A5A;
        repeat (4) @(posedge hclk);
        #1;
        chk(pad_oen, 16'h5A3C);
        chk(pad_out & 16'hA5C3, 16'h2482);
        chk(gpio_in, 16'h7E9A);
        @(posedge hclk);
        port_direction_reg <= 16'h0000;
        $display("test gpio done");
    endtask

    task automatic t_out();
        logic [15:0] oe, dg;
        logic [3:0]  p;
        logic [1:0]  c;
        logic [2:0]  ad;
        pat <= 23'h555555;
        for (int k = 0; k < 25; k++) begin
            p = OUT_TAB[k][7:4];
            c = OUT_TAB[k][3:2];
            bus(1'h1, ADDR_SEL_LOW, 32'(c) << (2 * p), r);
            run <= 1'h1;
            repeat (3) @(posedge hclk);
            #1;
            oe = 16'hFFFF;
            oe[p] = OUT_TAB[k][1];
            ad = (c == FUNC_ALT3 && p >= 4'hA && p <= 4'hC) ? 3'h1 << (p - 4'hA) : 3'h0;
            dg = ~({13'h0000, ad} << 10);
            chk(pad_oen, oe);
            if (!OUT_TAB[k][1]) chk(pad_out[p], OUT_TAB[k][0]);
            chk(adc_path_en, ad);
            chk(pad_digital_en, dg);
            @(posedge hclk);
            run <= 1'h0;
        end
        $display("test outputs done");
    endtask

    task automatic t_in();
        logic [19:0] ex;
        logic [15:0] gm;
        logic [3:0]  p;
        for (int k = 0; k < 20; k++) begin
            p = IN_TAB[k][5:2];
            bus(1'h1, ADDR_SEL_LOW, 32'(IN_TAB[k][1:0]) << (2 * p), r);
            for (int v = 0; v < 2; v++) begin
                @(posedge hclk);
                ext_lvl <= {16{v[0]}};
                repeat (4) @(posedge hclk);
                #1;
                ex = IN_IDLE;
                ex[k] = v[0];
                gm = {16{v[0]}};
                gm[p] = 1'h0;
                chk(in_v, ex);
                chk(gpio_in, gm);
            end
        end
        $display("test inputs done");
    endtask

    initial begin
        hresetn = 1'h0;
        hsel = 1'h1;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        gpio_out = 16'h0000;
        port_direction_reg = 16'h0000;
        ext_lvl = 16'h0000;
        pat = 23'h000000;
        run = 1'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs();
        t_gpio();
        t_out();
        t_in();
        summarize();
    end
endmodule
